// *** pkg/sbac_pkg.sv ***
// Constants for the serial byte access engine and its two control registers
// Overview of operation
// - Byte write: start, address+0, command, data, stop; slave acknowledges each byte.
// - Command bit 7 set means byte access; bits 6:0 index the register byte.
// - Byte read: address+0, command, repeated start, address+1, slave returns byte.
// - Byte 0 bits 7/6 pick power-down and stop drive mode, reset 0.
// - Byte 0 bit 2 selects PLL bandwidth, 0 high, 1 low, reset 1.
// - Byte 0 bit 1 selects fanout or PLL path, reset 1.
// - Byte 0 bit 0 selects half rate or full rate, reset 1.
// - Byte 1 bits 6,5,2,1 enable output pairs, reset 1.
// - Only slave address 1101110 with direction bit is answered.
// - Command bit 7 clear is block transfer, walking bytes upward from lowest.
// - All registers load defaults at power-up; no programming needed.
package sbac_pkg;
  localparam logic [6:0] SLAVE_ADDR      = 7'h6e;
  localparam logic [6:0] REG_CLOCK_PATH  = 7'h00;
  localparam logic [6:0] REG_PAIR_EN     = 7'h01;
  localparam logic [7:0] RST_CLOCK_PATH  = 8'h07;
  localparam logic [7:0] RST_PAIR_EN     = 8'hff;
  localparam logic [7:0] WMASK_CLOCK_PATH = 8'hc7;
  localparam logic [7:0] WMASK_PAIR_EN   = 8'h66;
  localparam int         CMD_BYTE_BIT    = 7;
  localparam int         PD_MODE_BIT     = 7;
  localparam int         STOP_MODE_BIT   = 6;
  localparam int         BW_BIT          = 2;
  localparam int         PATH_BIT        = 1;
  localparam int         RATE_BIT        = 0;
  localparam logic [7:0] BLOCK_COUNT     = 8'h02;
endpackage

// *** pkg/sbac_reg_if.sv ***
// Register access carrier between engine and register file
`timescale 1ns/1ps
interface sbac_reg_if;
  logic       wr_en;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport engine (output wr_en, output addr, output wdata, input rdata);
  modport regs   (input wr_en, input addr, input wdata, output rdata);
endinterface

// *** logic/sbac_regs.sv ***
// Two control registers with masked writes
`timescale 1ns/1ps
module sbac_regs (
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_n_i,
  // Register access
  sbac_reg_if.regs   bus,
  // Register contents
  output logic [7:0] clock_path_control_o,
  output logic [7:0] output_pair_enables_o
);
  logic [7:0] cp_q, cp_d, pe_q, pe_d;

  always_comb begin
    cp_d = cp_q;
    pe_d = pe_q;
    if (bus.wr_en && bus.addr == sbac_pkg::REG_CLOCK_PATH) begin
      cp_d = (bus.wdata & sbac_pkg::WMASK_CLOCK_PATH) |
             (sbac_pkg::RST_CLOCK_PATH & ~sbac_pkg::WMASK_CLOCK_PATH);
    end
    if (bus.wr_en && bus.addr == sbac_pkg::REG_PAIR_EN) begin
      pe_d = (bus.wdata & sbac_pkg::WMASK_PAIR_EN) |
             (sbac_pkg::RST_PAIR_EN & ~sbac_pkg::WMASK_PAIR_EN);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cp_q <= sbac_pkg::RST_CLOCK_PATH;
      pe_q <= sbac_pkg::RST_PAIR_EN;
    end else begin
      cp_q <= cp_d;
      pe_q <= pe_d;
    end
  end

  always_comb begin
    unique case (bus.addr)
      sbac_pkg::REG_CLOCK_PATH: bus.rdata = cp_q;
      sbac_pkg::REG_PAIR_EN:    bus.rdata = pe_q;
      default:                  bus.rdata = 8'h00;
    endcase
  end

  assign clock_path_control_o  = cp_q;
  assign output_pair_enables_o = pe_q;

  a_reserved_fixed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((cp_q & ~sbac_pkg::WMASK_CLOCK_PATH) ==
     (sbac_pkg::RST_CLOCK_PATH & ~sbac_pkg::WMASK_CLOCK_PATH)) &&
    ((pe_q & ~sbac_pkg::WMASK_PAIR_EN) == (sbac_pkg::RST_PAIR_EN & ~sbac_pkg::WMASK_PAIR_EN)))
    else $error("reserved bits changed");
  a_reset_defaults: assert property (@(posedge clk_i)
    $rose(rst_n_i) |-> (cp_q == sbac_pkg::RST_CLOCK_PATH && pe_q == sbac_pkg::RST_PAIR_EN))
    else $error("defaults not loaded");
endmodule

// *** logic/sbac_top.sv ***
// Serial slave byte and block access engine with control outputs
`timescale 1ns/1ps
module sbac_top (
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_n_i,
  // Serial bus pins
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  output logic       sda_o,
  output logic       sda_oe_o,
  // Control outputs
  output logic       pd_tristate_o,
  output logic       stop_tristate_o,
  output logic       pll_bandwidth_select_o,
  output logic       pll_path_o,
  output logic       half_rate_select_o,
  output logic [3:0] differential_output_pair_en_o
);
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_CMD, S_WDATA, S_RDATA, S_ACK, S_RACK, S_IGNORE
  } sbac_state_t;

  sbac_reg_if rif ();
  logic [7:0] cp, pe;

  sbac_regs sbac_regs_inst (
    .clk_i                 (clk_i),
    .rst_n_i               (rst_n_i),
    .bus                   (rif),
    .clock_path_control_o  (cp),
    .output_pair_enables_o (pe)
  );

  // ****************************************
  // Pin edge detection
  // ****************************************
  logic scl_q, sda_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_i && !scl_q;
  assign scl_fall = !scl_i && scl_q;
  assign start_c  = scl_i && scl_q && sda_q && !sda_i;
  assign stop_c   = scl_i && scl_q && !sda_q && sda_i;

  // ****************************************
  // Transfer state
  // ****************************************
  sbac_state_t st_q, st_d, nx_q, nx_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  sh_q, sh_d;
  logic [6:0]  idx_q, idx_d;
  logic        blk_q, blk_d, cnt1_q, cnt1_d, drv_q, drv_d, wr_d;

  // Bit count runs 0..8 so the clock fall right after a start is not a full byte
  always_comb begin
    st_d   = st_q;
    nx_d   = nx_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    idx_d  = idx_q;
    blk_d  = blk_q;
    cnt1_d = cnt1_q;
    drv_d  = drv_q;
    wr_d   = 1'b0;
    if (stop_c) begin
      st_d  = S_IDLE;
      drv_d = 1'b0;
    end else if (start_c) begin
      st_d  = S_ADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end else if (scl_rise && (st_q == S_ADDR || st_q == S_CMD || st_q == S_WDATA)) begin
      sh_d  = {sh_q[6:0], sda_i};
      cnt_d = cnt_q + 4'h1;
    end else if (scl_rise && st_q == S_RACK) begin
      // Master nack ends the read burst, ack moves to the next byte
      if (sda_i) st_d = S_IGNORE;
      else idx_d = idx_q + 7'h01;
    end else if (scl_fall) begin
      unique case (st_q)
        S_ADDR: if (cnt_q == 4'h8) begin
          if (sh_q[7:1] == sbac_pkg::SLAVE_ADDR) begin
            drv_d = 1'b1;
            st_d  = S_ACK;
            nx_d  = sh_q[0] ? S_RDATA : S_CMD;
            if (sh_q[0]) sh_d = rif.rdata;
          end else begin
            st_d = S_IGNORE;
          end
        end
        S_CMD: if (cnt_q == 4'h8) begin
          blk_d  = !sh_q[sbac_pkg::CMD_BYTE_BIT];
          idx_d  = sh_q[sbac_pkg::CMD_BYTE_BIT] ? sh_q[6:0] : 7'h00;
          cnt1_d = sh_q[sbac_pkg::CMD_BYTE_BIT];
          drv_d  = 1'b1;
          st_d   = S_ACK;
          nx_d   = S_WDATA;
        end
        S_WDATA: if (cnt_q == 4'h8) begin
          if (cnt1_q) begin
            wr_d = 1'b1;
            if (blk_q) idx_d = idx_q + 7'h01;
          end
          cnt1_d = 1'b1;
          drv_d  = 1'b1;
          st_d   = S_ACK;
          nx_d   = S_WDATA;
        end
        S_ACK: begin
          st_d  = nx_q;
          cnt_d = 4'h0;
          drv_d = (nx_q == S_RDATA) ? !sh_q[7] : 1'b0;
        end
        S_RDATA: begin
          if (cnt_q == 4'h7) begin
            drv_d = 1'b0;
            st_d  = S_RACK;
          end else begin
            sh_d  = {sh_q[6:0], 1'b0};
            drv_d = !sh_q[6];
          end
          cnt_d = cnt_q + 4'h1;
        end
        S_RACK: begin
          // Next byte loads once the acked index has moved on
          sh_d  = rif.rdata;
          drv_d = !rif.rdata[7];
          cnt_d = 4'h0;
          st_d  = S_RDATA;
        end
        S_IDLE, S_IGNORE: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q   <= S_IDLE;
      nx_q   <= S_IDLE;
      cnt_q  <= 4'h0;
      sh_q   <= 8'h00;
      idx_q  <= 7'h00;
      blk_q  <= 1'b0;
      cnt1_q <= 1'b0;
      drv_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      nx_q   <= nx_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      idx_q  <= idx_d;
      blk_q  <= blk_d;
      cnt1_q <= cnt1_d;
      drv_q  <= drv_d;
    end
  end

  // Block writes skip the leading byte count; byte writes store the first byte
  assign rif.wr_en = wr_d;
  assign rif.addr  = idx_q;
  assign rif.wdata = sh_q;

  assign sda_o    = 1'b0;
  assign sda_oe_o = drv_q;

  // ****************************************
  // Control outputs
  // ****************************************
  // drive modes, PLL bandwidth, path and rate selects, output pair enables
  assign pd_tristate_o   = cp[sbac_pkg::PD_MODE_BIT];
  assign stop_tristate_o = cp[sbac_pkg::STOP_MODE_BIT];
  assign pll_bandwidth_select_o = cp[sbac_pkg::BW_BIT];
  assign pll_path_o = cp[sbac_pkg::PATH_BIT];
  assign half_rate_select_o = cp[sbac_pkg::RATE_BIT];
  assign differential_output_pair_en_o = {pe[6], pe[5], pe[2], pe[1]};

  // ****************************************
  // Checks
  // ****************************************
  // no acknowledge to foreign address
  a_addr_ack: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q == S_ADDR && cnt_q == 4'h8 && scl_fall && sh_q[7:1] != sbac_pkg::SLAVE_ADDR)
    |=> (st_q == S_IGNORE && !sda_oe_o))
    else $error("acknowledged wrong address");
  a_ack_drive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q == S_ADDR && cnt_q == 4'h8 && scl_fall && sh_q[7:1] == sbac_pkg::SLAVE_ADDR)
    |=> (sda_oe_o && st_q == S_ACK))
    else $error("missing address acknowledge");
  a_cmd_index: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q == S_CMD && cnt_q == 4'h8 && scl_fall && sh_q[7])
    |=> (idx_q == $past(sh_q[6:0]) && !blk_q))
    else $error("wrong byte index");
  a_block_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q == S_CMD && cnt_q == 4'h8 && scl_fall && !sh_q[7])
    |=> (idx_q == 7'h00 && blk_q))
    else $error("block index not zero");
  // read data moves only on clock fall
  a_read_data: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q == S_RDATA && !start_c && !stop_c && !scl_fall) |=> (sda_oe_o == $past(sda_oe_o)))
    else $error("read data changed off edge");
  a_read_nack: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q == S_RACK && scl_rise && sda_i) |=> (st_q == S_IGNORE && !sda_oe_o))
    else $error("read went on after nack");
  a_pair_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rif.wr_en && rif.addr == sbac_pkg::REG_PAIR_EN) |=>
    (differential_output_pair_en_o == {$past(rif.wdata[6]), $past(rif.wdata[5]),
     $past(rif.wdata[2]), $past(rif.wdata[1])}))
    else $error("pair enable write lost");
  a_mode_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rif.wr_en && rif.addr == sbac_pkg::REG_CLOCK_PATH) |=>
    (pd_tristate_o == $past(rif.wdata[sbac_pkg::PD_MODE_BIT])
     && stop_tristate_o == $past(rif.wdata[sbac_pkg::STOP_MODE_BIT])))
    else $error("mode write lost");
  a_bw_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rif.wr_en && rif.addr == sbac_pkg::REG_CLOCK_PATH) |=>
    (pll_bandwidth_select_o == $past(rif.wdata[sbac_pkg::BW_BIT])))
    else $error("bandwidth write lost");
  a_path_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rif.wr_en && rif.addr == sbac_pkg::REG_CLOCK_PATH) |=>
    (pll_path_o == $past(rif.wdata[sbac_pkg::PATH_BIT])))
    else $error("path write lost");
  a_rate_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rif.wr_en && rif.addr == sbac_pkg::REG_CLOCK_PATH) |=>
    (half_rate_select_o == $past(rif.wdata[sbac_pkg::RATE_BIT])))
    else $error("rate write lost");
  a_stop_rel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    stop_c |=> (!sda_oe_o && st_q == S_IDLE))
    else $error("line held after stop");
endmodule

// *** testbench/sbac_host.sv ***
// Host controller model that clocks byte and block transfers
`timescale 1ns/1ps
module sbac_host (
  // Clock and device pull
  input  wire logic clk_i,
  input  wire logic sda_oe_i,
  // Bus lines
  output logic      scl_o,
  output logic      sda_o
);
  logic drv_q;
  initial begin
    scl_o = 1'b1;
    drv_q = 1'b1;
  end
  // Pulled-up data line
  assign sda_o = drv_q & ~sda_oe_i;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One bit, data changed while clock low
  task automatic bit_io(input logic d, output logic r);
    drv_q <= d;
    tick(3);
    scl_o <= 1'b1;
    tick(2);
    r = sda_o;
    tick(2);
    scl_o <= 1'b0;
    tick(1);
  endtask
  task automatic xfer(input logic [7:0] w, input logic m, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(m, a);
  endtask
  // Start when s is 1, stop when 0
  task automatic cond(input logic s);
    drv_q <= s;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    drv_q <= ~s;
    tick(4);
    if (s) scl_o <= 1'b0;
    tick(1);
  endtask
  task automatic op(input logic [6:0] a, input logic [7:0] cmd, input int nw, input int nr,
                    input logic [7:0] wd [3], output logic [7:0] rd [2], output logic nak);
    logic [7:0] r;
    logic       k;
    cond(1'b1);
    xfer({a, 1'b0}, 1'b1, r, nak);
    xfer(cmd, 1'b1, r, k);
    nak |= k;
    for (int i = 0; i < nw; i++) begin
      xfer(wd[i], 1'b1, r, k);
      nak |= k;
    end
    if (nr > 0) begin
      cond(1'b1);
      xfer({a, 1'b1}, 1'b1, r, k);
      nak |= k;
      for (int i = 0; i < nr; i++) xfer(8'hff, i == nr - 1, rd[i], k);
    end
    cond(1'b0);
  endtask
endmodule

// *** testbench/tb_sbac_top.sv ***
// Self-checking bench for the serial byte access engine
`timescale 1ns/1ps
module tb_sbac_top;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       scl, sda, sda_o, sda_oe_o, pd, stp, bw, path, half, nak;
  logic [3:0] en;
  logic [7:0] rd [2];
  int         err_count = 0;
  int         checked = 0;
  always #12.5 clk_i = ~clk_i;
  sbac_top sbac_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .pd_tristate_o(pd), .stop_tristate_o(stp),
    .pll_bandwidth_select_o(bw), .pll_path_o(path), .half_rate_select_o(half),
    .differential_output_pair_en_o(en));
  sbac_host sbac_host_inst (.clk_i(clk_i), .sda_oe_i(sda_oe_o), .scl_o(scl), .sda_o(sda));
  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pins(input logic [7:0] r0, input logic [7:0] r1);
    cmp({pd, stp, bw, path, half, en}, {r0[7], r0[6], r0[2:0], r1[6:5], r1[2:1]});
  endtask
  task automatic rd_byte(input logic [7:0] cmd, input logic [7:0] exp);
    sbac_host_inst.op(sbac_pkg::SLAVE_ADDR, cmd, 0, 1, '{8'h00, 8'h00, 8'h00}, rd, nak);
    cmp({nak, rd[0]}, {1'b0, exp});
  endtask
  task automatic wr_byte(input logic [7:0] cmd, input logic [7:0] d);
    sbac_host_inst.op(sbac_pkg::SLAVE_ADDR, cmd, 1, 0, '{d, 8'h00, 8'h00}, rd, nak);
    cmp(nak, 1'b0);
  endtask
  task automatic t_reset;
    cmp(sda_oe_o, 1'b0);
    cmp(sda_o, 1'b0);
    pins(8'h07, 8'hff);
    rd_byte(8'h80, 8'h07);
    rd_byte(8'h81, 8'hff);
  endtask
  task automatic t_byte_wr;
    wr_byte(8'h80, 8'hff);
    pins(8'hc7, 8'hff);
    rd_byte(8'h80, 8'hc7);
    wr_byte(8'h80, 8'h38);
    pins(8'h00, 8'hff);
    rd_byte(8'h80, 8'h00);
    wr_byte(8'h81, 8'h00);
    pins(8'h00, 8'h99);
    rd_byte(8'h81, 8'h99);
  endtask
  task automatic t_refuse;
    sbac_host_inst.op(7'h6f, 8'h81, 1, 0, '{8'hff, 8'h00, 8'h00}, rd, nak);
    cmp(nak, 1'b1);
    pins(8'h00, 8'h99);
    wr_byte(8'h82, 8'hff);
    rd_byte(8'h82, 8'h00);
    pins(8'h00, 8'h99);
  endtask
  task automatic t_block;
    sbac_host_inst.op(sbac_pkg::SLAVE_ADDR, 8'h00, 3, 0, '{8'h02, 8'h86, 8'h22}, rd, nak);
    cmp(nak, 1'b0);
    pins(8'h86, 8'hbb);
    sbac_host_inst.op(sbac_pkg::SLAVE_ADDR, 8'h00, 0, 2, '{8'h00, 8'h00, 8'h00}, rd, nak);
    cmp({nak, rd[0], rd[1]}, {1'b0, 8'h86, 8'hbb});
    rd_byte(8'h81, 8'hbb);
  endtask
  task automatic t_rst;
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    cmp(sda_oe_o, 1'b0);
    pins(8'h07, 8'hff);
    rd_byte(8'h80, 8'h07);
    rd_byte(8'h81, 8'hff);
  endtask
  task automatic wrap_up;
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_byte_wr();
    t_refuse();
    t_block();
    t_rst();
    wrap_up();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    wrap_up();
  end
endmodule
